// ### hw/fu_uart.sv
// FIFO UART with flow control, classic Wishbone slave
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps

// Summary of operation
// - Separate TX and RX FIFOs, depth parameter, default sixteen bytes.
// - Software reads TX and RX FIFO fill levels directly.
// - Five to eight data bits, one start bit added and removed.
// - Parity even, odd, forced one, forced zero, or none.
// - One stop bit, or 1.5 for five bits, else two.
// - Programmable baud divisor reaching one megabit and standard rates.
// - Without auto flow, RTS follows software bit, CTS is readable and interrupts but does not gate sending.
// - Auto flow negates RTS when RX level exceeds 8, 11, 13 or 15.
// - Auto flow starts characters only while CTS asserted; remote stops promptly.
// - Data read pops RX FIFO; data write pushes TX FIFO.
// - Independent flush controls for TX and RX FIFOs.
// - Status shows TX FIFO empty and shifter busy separately.
// - Status flags parity, framing, break, data ready and overrun.
// - RX interrupt when level reaches trigger 1, 4, 8 or 14.
// - RX interrupt when data waits four idle character times.
// - TX-empty interrupt when last byte leaves FIFO and starts sending.
// - Line interrupt on overrun, or on a parity or framing error in a received byte as it is stored.
// - Break detected when line low a whole frame; raises line interrupt.
// - Modem interrupt on every CTS level change.
// - Four interrupt sources each have an independent enable.
// - A start pulse gone high at mid-bit is rejected.
// - Loopback routes transmitter output to receiver internally.
module fu_uart #(
   parameter int DEPTH = 16,
   parameter int LW = $clog2(DEPTH + 1)
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic txd,
   input wire logic rxd,
   output logic rts_n,
   input wire logic cts_n,
   output logic irq
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [31:0] rdata;
      logic ack;
      logic [3:0] ien;
      logic [7:6] trig;
      logic [7:0] lctl;
      logic [7:0] mctl;
      logic [15:0] div;
      logic [15:0] divcnt;
      logic [AW-1:0] txwp;
      logic [AW-1:0] txrp;
      logic [LW-1:0] txlvl;
      logic [AW-1:0] rxwp;
      logic [AW-1:0] rxrp;
      logic [LW-1:0] rxlvl;
      fu_pkg::fu_bit_t ts;
      logic [3:0] tos;
      logic [2:0] tbit;
      logic [7:0] tsh;
      logic tpar;
      logic tx_line;
      logic thre_int;
      fu_pkg::fu_bit_t rs;
      logic [3:0] ros;
      logic [2:0] rbit;
      logic [7:0] rsh;
      logic rpar;
      logic rallz;
      logic oe;
      logic ls_int;
      logic ms_int;
      logic [9:0] tocnt;
      logic rx1;
      logic rx2;
      logic cts1;
      logic cts2;
      logic cts_prev;
   } fu_state_t;

   fu_state_t st;
   fu_state_t next_st;
   logic [7:0] txmem [DEPTH];
   fu_pkg::fu_rx_word_t rxmem [DEPTH];
   fu_pkg::fu_wb_req_t req;
   logic tick;
   logic rx_in;
   logic cts_on;
   logic wr_ok;
   logic rd_ok;
   logic push_tx;
   logic pop_rx;
   logic pop_tx;
   logic push_rx;
   logic [3:0] nbits;
   logic [3:0] stop_len;
   logic rx_stop_done;
   logic thr_hit;
   logic [4:0] trig_lvl;
   logic [4:0] rts_thr;
   logic to_hit;
   logic [9:0] to_len;
   logic [7:0] lsr;
   logic [3:0] iid;
   fu_pkg::fu_rx_word_t head;
   fu_pkg::fu_rx_word_t rx_word;

   assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i,
                  cyc: wb_cyc_i, stb: wb_stb_i};
   assign wr_ok = req.cyc && req.stb && req.we && !st.ack && req.sel[0];
   assign rd_ok = req.cyc && req.stb && !req.we && !st.ack;
   assign head = rxmem[st.rxrp];
   assign nbits = {2'b00, st.lctl[1:0]} + 4'h5;
   // Two stop bits when the stop bit is set, except 1.5 for five-bit chars; else one
   assign stop_len = st.lctl[fu_pkg::LCTL_STOP] ? 4'h2 : 4'h1;
   assign rx_in = st.mctl[fu_pkg::MCTL_LOOP] ? st.tx_line : st.rx2;
   assign cts_on = !st.cts2;
   assign tick = (st.divcnt == 16'h0001) || (st.div == 16'h0000);
   assign push_tx = wr_ok && req.adr[4:0] == fu_pkg::ADDR_DATA && st.txlvl != LW'(DEPTH);
   assign pop_rx = rd_ok && req.adr[4:0] == fu_pkg::ADDR_DATA && st.rxlvl != '0;
   assign rx_stop_done = st.rs == fu_pkg::FU_STOP && tick && st.ros == fu_pkg::OSR_LAST;
   assign push_rx = rx_stop_done && st.rxlvl != LW'(DEPTH);
   assign pop_tx = st.ts == fu_pkg::FU_IDLE && tick && st.txlvl != '0
                   && (!st.mctl[fu_pkg::MCTL_AUTO] || cts_on);
   assign rx_word = '{data: st.rsh, perr: st.lctl[fu_pkg::LCTL_PEN]
                      && (st.rpar != rx_parity(st.rsh, st.lctl[1:0], st.lctl[5:4])),
                      ferr: !rx_in, brk: st.rallz && !rx_in};

   always_comb
   begin
      case (st.trig)
         2'b00: trig_lvl = 5'd1;
         2'b01: trig_lvl = 5'd4;
         2'b10: trig_lvl = 5'd8;
         default: trig_lvl = 5'd14;
      endcase
      case (st.mctl[7:6])
         2'b00: rts_thr = 5'd8;
         2'b01: rts_thr = 5'd11;
         2'b10: rts_thr = 5'd13;
         default: rts_thr = 5'd15;
      endcase
   end

   assign thr_hit = 5'(st.rxlvl) >= trig_lvl;
   // Char time about ten bits of sixteen ticks
   assign to_len = 10'(fu_pkg::TIMEOUT_CHARS * 16 * 10);
   assign to_hit = st.rxlvl != '0 && st.tocnt >= to_len;
   assign lsr = {1'b0, st.ts == fu_pkg::FU_IDLE && st.txlvl == '0, st.txlvl == '0,
                 head.brk && st.rxlvl != '0, head.ferr && st.rxlvl != '0,
                 head.perr && st.rxlvl != '0, st.oe, st.rxlvl != '0};

   // Gated sources, priority line > rx > tx > modem
   always_comb
   begin
      iid = 4'h1;
      if (st.ien[fu_pkg::IEN_MS] && st.ms_int)
         iid = 4'h0;
      if (st.ien[fu_pkg::IEN_TX] && st.thre_int)
         iid = 4'h2;
      if (st.ien[fu_pkg::IEN_RX] && to_hit)
         iid = 4'hC;
      if (st.ien[fu_pkg::IEN_RX] && thr_hit)
         iid = 4'h4;
      if (st.ien[fu_pkg::IEN_LS] && st.ls_int)
         iid = 4'h6;
   end

   function automatic logic rx_parity(input logic [7:0] d, input logic [1:0] len,
                                      input logic [1:0] psel);
      logic p;
      p = ^(d & (8'hFF >> (2'h3 - len)));
      case (psel)
         2'b00: rx_parity = ~p;
         2'b01: rx_parity = p;
         2'b10: rx_parity = 1'b1;
         default: rx_parity = 1'b0;
      endcase
   endfunction : rx_parity

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      next_st = st;
      next_st.ack = req.cyc && req.stb && !st.ack;
      next_st.rx1 = rxd;
      next_st.rx2 = st.rx1;
      next_st.cts1 = cts_n;
      next_st.cts2 = st.cts1;
      next_st.cts_prev = st.cts2;
      next_st.divcnt = tick ? st.div : st.divcnt - 16'h0001;
      if (st.rxlvl == '0 || push_rx || pop_rx)
         next_st.tocnt = '0;
      else if (tick && !to_hit)
         next_st.tocnt = st.tocnt + 10'h001;

      // Register access; reads of status clear the sticky flags
      next_st.rdata = '0;
      if (rd_ok)
      begin
         case (req.adr[4:0])
            fu_pkg::ADDR_DATA: next_st.rdata = {24'h000000, head.data};
            fu_pkg::ADDR_IEN: next_st.rdata = {28'h0, st.ien};
            fu_pkg::ADDR_FCTL: next_st.rdata = {8'h00, 8'(st.rxlvl), 8'(st.txlvl),
                                                st.trig, 6'h00};
            fu_pkg::ADDR_LCTL: next_st.rdata = {24'h000000, st.lctl};
            fu_pkg::ADDR_MCTL: next_st.rdata = {23'h0, cts_on, st.mctl};
            fu_pkg::ADDR_LSTAT:
            begin
               next_st.rdata = {24'h000000, lsr};
               next_st.oe = 1'b0;
               next_st.ls_int = 1'b0;
            end
            fu_pkg::ADDR_ISTAT:
            begin
               next_st.rdata = {28'h0, iid};
               next_st.thre_int = 1'b0;
               next_st.ms_int = 1'b0;
            end
            fu_pkg::ADDR_DIV: next_st.rdata = {16'h0000, st.div};
            default: next_st.rdata = '0;
         endcase
      end
      // Set after the status-read clear so a level change is never lost
      if (st.cts_prev != st.cts2)
         next_st.ms_int = 1'b1;
      if (wr_ok)
      begin
         case (req.adr[4:0])
            fu_pkg::ADDR_IEN: next_st.ien = req.dat[3:0];
            fu_pkg::ADDR_FCTL:
            begin
               next_st.trig = req.dat[7:6];
               if (req.dat[fu_pkg::FCTL_RXCLR])
               begin
                  next_st.rxwp = '0;
                  next_st.rxrp = '0;
               end
               if (req.dat[fu_pkg::FCTL_TXCLR])
               begin
                  next_st.txwp = '0;
                  next_st.txrp = '0;
               end
            end
            fu_pkg::ADDR_LCTL: next_st.lctl = req.dat[7:0];
            fu_pkg::ADDR_MCTL: next_st.mctl = req.dat[7:0];
            fu_pkg::ADDR_DIV: next_st.div = req.dat[15:0];
            default: next_st.div = next_st.div;
         endcase
      end
      if (push_tx)
         next_st.txwp = AW'((32'(st.txwp) + 1) % DEPTH);

      // Transmitter, one bit every sixteen ticks
      if (tick)
      begin
         next_st.tos = st.tos + 4'h1;
         case (st.ts)
            fu_pkg::FU_IDLE:
            begin
               next_st.tx_line = 1'b1;
               next_st.tos = '0;
               if (pop_tx)
               begin
                  next_st.tsh = txmem[st.txrp];
                  next_st.tpar = rx_parity(txmem[st.txrp], st.lctl[1:0], st.lctl[5:4]);
                  next_st.txrp = AW'((32'(st.txrp) + 1) % DEPTH);
                  next_st.ts = fu_pkg::FU_START;
                  next_st.tx_line = 1'b0;
                  if (st.txlvl == LW'(1))
                     next_st.thre_int = 1'b1;
               end
            end
            fu_pkg::FU_START:
               if (st.tos == fu_pkg::OSR_LAST)
               begin
                  next_st.ts = fu_pkg::FU_DATA;
                  next_st.tbit = '0;
                  next_st.tx_line = st.tsh[0];
               end
            fu_pkg::FU_DATA:
               if (st.tos == fu_pkg::OSR_LAST)
               begin
                  next_st.tbit = st.tbit + 3'h1;
                  next_st.tx_line = st.tsh[3'(st.tbit + 3'h1)];
                  if (4'(st.tbit) + 4'h1 == nbits)
                  begin
                     next_st.ts = st.lctl[fu_pkg::LCTL_PEN] ? fu_pkg::FU_PAR : fu_pkg::FU_STOP;
                     next_st.tx_line = st.lctl[fu_pkg::LCTL_PEN] ? st.tpar : 1'b1;
                     next_st.tbit = '0;
                  end
               end
            fu_pkg::FU_PAR:
               if (st.tos == fu_pkg::OSR_LAST)
               begin
                  next_st.ts = fu_pkg::FU_STOP;
                  next_st.tx_line = 1'b1;
               end
            fu_pkg::FU_STOP:
               if ((st.tos == fu_pkg::OSR_LAST && 4'(st.tbit) + 4'h1 == stop_len)
                   || (st.lctl[fu_pkg::LCTL_STOP] && st.lctl[1:0] == 2'b00
                       && st.tbit == 3'h1 && st.tos == fu_pkg::OSR_HALF_STOP))
                  next_st.ts = fu_pkg::FU_IDLE;
               else if (st.tos == fu_pkg::OSR_LAST)
                  next_st.tbit = st.tbit + 3'h1;
            default: next_st.ts = fu_pkg::FU_IDLE;
         endcase

         // Receiver, centre sampled
         next_st.ros = st.ros + 4'h1;
         case (st.rs)
            fu_pkg::FU_IDLE:
            begin
               next_st.ros = '0;
               if (!rx_in)
                  next_st.rs = fu_pkg::FU_START;
            end
            fu_pkg::FU_START:
               if (st.ros == fu_pkg::OSR_MID)
               begin
                  next_st.ros = '0;
                  next_st.rbit = '0;
                  next_st.rallz = 1'b1;
                  next_st.rs = rx_in ? fu_pkg::FU_IDLE : fu_pkg::FU_DATA;
               end
            fu_pkg::FU_DATA:
               if (st.ros == fu_pkg::OSR_LAST)
               begin
                  next_st.rsh = {rx_in, st.rsh[7:1]};
                  next_st.rallz = st.rallz && !rx_in;
                  next_st.rbit = st.rbit + 3'h1;
                  if (4'(st.rbit) + 4'h1 == nbits)
                  begin
                     next_st.rsh = {rx_in, st.rsh[7:1]} >> (4'h8 - nbits);
                     next_st.rs = st.lctl[fu_pkg::LCTL_PEN] ? fu_pkg::FU_PAR : fu_pkg::FU_STOP;
                  end
               end
            fu_pkg::FU_PAR:
               if (st.ros == fu_pkg::OSR_LAST)
               begin
                  next_st.rpar = rx_in;
                  next_st.rallz = st.rallz && !rx_in;
                  next_st.rs = fu_pkg::FU_STOP;
                  next_st.ros = '0;
               end
            fu_pkg::FU_STOP:
               if (st.ros == fu_pkg::OSR_LAST)
               begin
                  next_st.rs = fu_pkg::FU_IDLE;
                  if (push_rx)
                  begin
                     next_st.rxwp = AW'((32'(st.rxwp) + 1) % DEPTH);
                     if (rx_word.perr || rx_word.ferr)
                        next_st.ls_int = 1'b1;
                  end
                  else
                  begin
                     next_st.oe = 1'b1;
                     next_st.ls_int = 1'b1;
                  end
               end
            default: next_st.rs = fu_pkg::FU_IDLE;
         endcase
      end
      if (pop_rx)
         next_st.rxrp = AW'((32'(st.rxrp) + 1) % DEPTH);

      // Flush wins over same-cycle traffic in that FIFO only
      if (wr_ok && req.adr[4:0] == fu_pkg::ADDR_FCTL && req.dat[fu_pkg::FCTL_RXCLR])
      begin
         next_st.rxwp = '0;
         next_st.rxrp = '0;
         next_st.rxlvl = '0;
      end
      else
         next_st.rxlvl = st.rxlvl + LW'(push_rx) - LW'(pop_rx);
      if (wr_ok && req.adr[4:0] == fu_pkg::ADDR_FCTL && req.dat[fu_pkg::FCTL_TXCLR])
      begin
         next_st.txwp = '0;
         next_st.txrp = '0;
         next_st.txlvl = '0;
      end
      else
         next_st.txlvl = st.txlvl + LW'(push_tx) - LW'(pop_tx);
   end

   // ****************************************************************
   // Registers and FIFO storage
   // ****************************************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st <= '0;
         st.div <= fu_pkg::DIV_RESET;
         st.divcnt <= fu_pkg::DIV_RESET;
         st.tx_line <= 1'b1;
         st.rx1 <= 1'b1;
         st.rx2 <= 1'b1;
         st.cts1 <= 1'b1;
         st.cts2 <= 1'b1;
         st.cts_prev <= 1'b1;
         st.lctl <= 8'h03;
      end
      else
         st <= next_st;
   end

   // Storage has no reset; a data read with the RX FIFO empty returns the entry at the read pointer
   always_ff @(posedge mclk)
   begin
      if (push_tx)
         txmem[st.txwp] <= req.dat[7:0];
      if (push_rx)
         rxmem[st.rxwp] <= rx_word;
   end

   assign wb_dat_o = st.rdata;
   assign wb_ack_o = st.ack;
   assign txd = st.tx_line;
   // Auto mode drops RTS above threshold
   assign rts_n = st.mctl[fu_pkg::MCTL_AUTO] ? (5'(st.rxlvl) > rts_thr)
                                             : !st.mctl[fu_pkg::MCTL_RTS];
   assign irq = iid != 4'h1;

endmodule : fu_uart

// ### hw/fu_pkg.sv
// Package: register map, field layouts, reset values and types of the FIFO UART
package fu_pkg;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [4:0] ADDR_DATA = 5'h00;
   localparam logic [4:0] ADDR_IEN = 5'h04;
   localparam logic [4:0] ADDR_FCTL = 5'h08;
   localparam logic [4:0] ADDR_LCTL = 5'h0C;
   localparam logic [4:0] ADDR_MCTL = 5'h10;
   localparam logic [4:0] ADDR_LSTAT = 5'h14;
   localparam logic [4:0] ADDR_ISTAT = 5'h18;
   localparam logic [4:0] ADDR_DIV = 5'h1C;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int IEN_RX = 0;
   localparam int IEN_TX = 1;
   localparam int IEN_LS = 2;
   localparam int IEN_MS = 3;
   localparam int FCTL_RXCLR = 1;
   localparam int FCTL_TXCLR = 2;
   localparam int FCTL_TRIG_LO = 6;
   localparam int LCTL_LEN_LO = 0;
   localparam int LCTL_STOP = 2;
   localparam int LCTL_PEN = 3;
   localparam int LCTL_PSEL_LO = 4;
   localparam int MCTL_RTS = 1;
   localparam int MCTL_LOOP = 4;
   localparam int MCTL_AUTO = 5;
   localparam int MCTL_THR_LO = 6;
   localparam int LS_DR = 0;
   localparam int LS_OE = 1;
   localparam int LS_PE = 2;
   localparam int LS_FE = 3;
   localparam int LS_BI = 4;
   localparam int LS_TEMT_FIFO = 5;
   localparam int LS_TEMT_ALL = 6;

   // ****************************************************************
   // Reset values and counts
   // ****************************************************************
   localparam logic [15:0] DIV_RESET = 16'h0001;
   localparam logic [3:0] OSR_LAST = 4'hF;
   localparam logic [3:0] OSR_MID = 4'h7;
   localparam logic [3:0] OSR_HALF_STOP = 4'h7;
   localparam int TIMEOUT_CHARS = 4;
   localparam logic [2:0] TRIG_1 = 3'h1;

   // Parity select: 0 odd, 1 even, 2 forced one, 3 forced zero
   typedef enum logic [2:0]
   {
      FU_IDLE = 3'b000,
      FU_START = 3'b001,
      FU_DATA = 3'b010,
      FU_PAR = 3'b011,
      FU_STOP = 3'b100
   } fu_bit_t;

   typedef struct packed
   {
      logic [7:0] data;
      logic perr;
      logic ferr;
      logic brk;
   } fu_rx_word_t;

   typedef struct packed
   {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic cyc;
      logic stb;
   } fu_wb_req_t;

endpackage : fu_pkg

// ### verif/fu_uart_props.sv
// Checker: bus timing, line framing and status relations of the FIFO UART
`timescale 1ns/10ps
module fu_uart_props (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic txd,
   input wire logic rxd,
   input wire logic rts_n,
   input wire logic cts_n,
   input wire logic irq
);
   // ****************
   // Helper state
   // ****************
   logic rd_ack;
   logic wr_ack;
   logic cts_q;
   logic [2:0] cts_age;
   logic ien_ms;
   assign rd_ack = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;
   assign wr_ack = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
   // Age of the clear-to-send level, so reads only judge a settled input
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cts_q <= 1'b1;
         cts_age <= 3'h0;
         ien_ms <= 1'b0;
      end
      else
      begin
         cts_q <= cts_n;
         cts_age <= (cts_n != cts_q) ? 3'h0 : ((cts_age == 3'h7) ? 3'h7 : cts_age + 3'h1);
         if (wr_ack && wb_adr_i[4:0] == fu_pkg::ADDR_IEN)
            ien_ms <= wb_dat_i[fu_pkg::IEN_MS];
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside acknowledge");
   AST_RTS_MAN: assert property (wr_ack && wb_adr_i[4:0] == fu_pkg::ADDR_MCTL
      && !wb_dat_i[fu_pkg::MCTL_AUTO] |-> rts_n == !wb_dat_i[fu_pkg::MCTL_RTS])
      else $error("request pin does not follow software bit");
   AST_BIT_LEN: assert property ($fell(txd) |-> (!txd) [*8])
      else $error("low bit on serial output shorter than half a bit");
   AST_TEMT: assert property (rd_ack && wb_adr_i[4:0] == fu_pkg::ADDR_LSTAT
      && wb_dat_o[fu_pkg::LS_TEMT_ALL] |-> wb_dat_o[fu_pkg::LS_TEMT_FIFO])
      else $error("shifter idle flag set with queue not empty");
   AST_ISTAT: assert property (rd_ack && wb_adr_i[4:0] == fu_pkg::ADDR_ISTAT
      |-> (wb_dat_o[3:0] == 4'h1) == !$past(irq))
      else $error("interrupt id disagrees with interrupt line");
   AST_CTS_READ: assert property (rd_ack && wb_adr_i[4:0] == fu_pkg::ADDR_MCTL
      && cts_age == 3'h7 |-> wb_dat_o[8] == !cts_n)
      else $error("clear-to-send readback wrong");
   AST_MODEM_IRQ: assert property ($changed(cts_n) && ien_ms |-> ##[1:6] irq)
      else $error("no modem interrupt on clear-to-send change");

   cover property (wr_ack && wb_adr_i[4:0] == fu_pkg::ADDR_DATA);
   cover property ($rose(rts_n));
   cover property (rd_ack && wb_adr_i[4:0] == fu_pkg::ADDR_LSTAT && wb_dat_o[fu_pkg::LS_OE]);
endmodule : fu_uart_props

bind fu_uart fu_uart_props u_props (.mclk(mclk), .rst(rst), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd(txd),
   .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n), .irq(irq));

// ### verif/fu_remote.sv
// Remote serial device model: 8N1 sender and receiver, one bit per BIT clocks
`timescale 1ns/10ps
module fu_remote #(
   parameter int BIT = 16
) (
   input wire logic mclk,
   input wire logic txd,
   input wire logic rts_n,
   output logic rxd,
   output logic cts_n
);
   logic [7:0] got;
   int ngot;
   initial
   begin
      rxd = 1'b1;
      cts_n = 1'b1;
      ngot = 0;
      got = 8'h0;
   end
   // Frame bits go out LSB first; idle line rests at mark level
   task automatic send(input logic [9:0] fr);
      int i;
      for (i = 0; i < 4000 && rts_n !== 1'b0; i++) @(posedge mclk);
      for (i = 0; i < 10; i++)
      begin
         rxd <= fr[i];
         repeat (BIT) @(posedge mclk);
      end
      rxd <= 1'b1;
      @(posedge mclk);
   endtask : send
   task automatic low(input int n);
      rxd <= 1'b0;
      repeat (n) @(posedge mclk);
      rxd <= 1'b1;
      @(posedge mclk);
   endtask : low
   always
   begin : rx_side
      int i;
      @(negedge txd);
      repeat (BIT / 2) @(posedge mclk);
      for (i = 0; i < 8; i++)
      begin
         repeat (BIT) @(posedge mclk);
         got[i] = txd;
      end
      ngot++;
      // Park on the stop bit so data edges never look like a start
      repeat (BIT) @(posedge mclk);
   end
endmodule : fu_remote

// ### verif/fu_uart_bench.sv
// Bench: register-level tests of the FIFO UART against a remote serial model
`timescale 1ns/10ps
`define CHK(nm, e, g) \
   begin \
      n_checks++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("wrong value %s exp %0h got %0h", nm, e, g); \
      end \
   end
module fu_uart_bench;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] adr = 32'h0;
   logic [31:0] dat = 32'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic ack, txd, rxd, rts_n, cts_n, irq;
   int err_count = 0;
   int n_checks = 0;
   int i, k, n;
   logic [7:0] fmt [5] = '{8'h00, 8'h0C, 8'h1D, 8'h2E, 8'h3B};
   always #2 mclk = ~mclk;
   fu_uart dut (.mclk(mclk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n), .irq(irq));
   fu_remote rem (.mclk(mclk), .txd(txd), .rts_n(rts_n), .rxd(rxd), .cts_n(cts_n));

   // ****************
   // Bus and wait tasks
   // ****************
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      int c;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {27'h0, a};
      dat <= d;
      for (c = 0; c < 20 && ack !== 1'b1; c++) @(posedge mclk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (c >= 20)
      begin
         err_count++;
         stop_test();
      end
   endtask : bus
   task automatic poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v);
      int c;
      bus(a, 1'b0, 32'h0);
      for (c = 0; c < 900 && (q & m) !== v; c++) bus(a, 1'b0, 32'h0);
      `CHK("poll", v, q & m);
      if (c >= 900)
         stop_test();
   endtask : poll

   // ****************
   // Test sequence
   // ****************
   initial
   begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      bus(fu_pkg::ADDR_LCTL, 1'b0, 32'h0);
      `CHK("lctl", 32'h3, q);
      bus(fu_pkg::ADDR_DIV, 1'b0, 32'h0);
      `CHK("div", 32'h1, q);
      bus(fu_pkg::ADDR_LSTAT, 1'b0, 32'h0);
      `CHK("lstat", 8'h60, q[7:0]);
      bus(fu_pkg::ADDR_ISTAT, 1'b0, 32'h0);
      `CHK("istat", 4'h1, q[3:0]);
      bus(5'h02, 1'b0, 32'h0);
      `CHK("unmapped", 32'h0, q);
      $display("test reset done");
      bus(fu_pkg::ADDR_MCTL, 1'b1, 32'h10);
      for (k = 0; k < 5; k++)
      begin
         bus(fu_pkg::ADDR_LCTL, 1'b1, {24'h0, fmt[k]});
         bus(fu_pkg::ADDR_DATA, 1'b1, 32'hA5);
         bus(fu_pkg::ADDR_LSTAT, 1'b0, 32'h0);
         `CHK("busy", 1'b0, q[6]);
         poll(fu_pkg::ADDR_LSTAT, 32'h1, 32'h1);
         `CHK("lerr", 3'h0, q[3:1]);
         bus(fu_pkg::ADDR_DATA, 1'b0, 32'h0);
         `CHK("loop", 8'hA5 & (8'hFF >> (3 - fmt[k][1:0])), q[7:0]);
      end
      $display("test loopback done");
      bus(fu_pkg::ADDR_LCTL, 1'b1, 32'h3);
      bus(fu_pkg::ADDR_MCTL, 1'b1, 32'h20);
      `CHK("rts_low", 1'b0, rts_n);
      for (i = 0; i < 9; i++) rem.send({1'b1, 8'h40 + 8'(i), 1'b0});
      poll(fu_pkg::ADDR_FCTL, 32'h00FF0000, 32'h00090000);
      `CHK("rts_over", 1'b1, rts_n);
      bus(fu_pkg::ADDR_DATA, 1'b0, 32'h0);
      `CHK("pop", 8'h40, q[7:0]);
      `CHK("rts_at8", 1'b0, rts_n);
      bus(fu_pkg::ADDR_FCTL, 1'b1, 32'h2);
      bus(fu_pkg::ADDR_FCTL, 1'b0, 32'h0);
      `CHK("flush", 16'h0, q[23:8]);
      $display("test auto flow done");
      bus(fu_pkg::ADDR_IEN, 1'b1, 32'h8);
      k = rem.ngot;
      bus(fu_pkg::ADDR_DATA, 1'b1, 32'h3C);
      repeat (300) @(posedge mclk);
      `CHK("cts_hold", k, rem.ngot);
      bus(fu_pkg::ADDR_LSTAT, 1'b0, 32'h0);
      `CHK("txq", 1'b0, q[5]);
      rem.cts_n <= 1'b0;
      for (n = 0; n < 800 && rem.ngot == k; n++) @(posedge mclk);
      if (n >= 800)
      begin
         err_count++;
         stop_test();
      end
      `CHK("txbyte", 8'h3C, rem.got);
      `CHK("mirq", 1'b1, irq);
      bus(fu_pkg::ADDR_ISTAT, 1'b0, 32'h0);
      `CHK("mid", 4'h0, q[3:0]);
      `CHK("mclr", 1'b0, irq);
      bus(fu_pkg::ADDR_MCTL, 1'b0, 32'h0);
      `CHK("cts", 1'b1, q[8]);
      bus(fu_pkg::ADDR_IEN, 1'b1, 32'h0);
      rem.cts_n <= 1'b1;
      repeat (8) @(posedge mclk);
      `CHK("masked", 1'b0, irq);
      $display("test transmit done");
      bus(fu_pkg::ADDR_MCTL, 1'b1, 32'h02);
      rem.low(4);
      repeat (300) @(posedge mclk);
      bus(fu_pkg::ADDR_LSTAT, 1'b0, 32'h0);
      `CHK("false_start", 1'b0, q[0]);
      rem.low(16 * 11);
      poll(fu_pkg::ADDR_LSTAT, 32'h11, 32'h11);
      // Let the all-ones frame that follows the break end first
      repeat (300) @(posedge mclk);
      bus(fu_pkg::ADDR_FCTL, 1'b1, 32'h2);
      bus(fu_pkg::ADDR_IEN, 1'b1, 32'h4);
      for (i = 0; i < 17; i++) rem.send({1'b1, 8'(i), 1'b0});
      poll(fu_pkg::ADDR_ISTAT, 32'hF, 32'h6);
      poll(fu_pkg::ADDR_LSTAT, 32'h2, 32'h2);
      bus(fu_pkg::ADDR_FCTL, 1'b0, 32'h0);
      `CHK("full", 8'h10, q[23:16]);
      bus(fu_pkg::ADDR_DATA, 1'b0, 32'h0);
      `CHK("head", 8'h00, q[7:0]);
      bus(fu_pkg::ADDR_FCTL, 1'b1, 32'hC0);
      bus(fu_pkg::ADDR_IEN, 1'b1, 32'h1);
      bus(fu_pkg::ADDR_ISTAT, 1'b0, 32'h0);
      `CHK("rx_trig", 4'h4, q[3:0]);
      $display("test receive errors done");
      stop_test();
   end
endmodule : fu_uart_bench
